//--- pei_handler.sv
// power event interrupt handler core with its register file
// assumes event pins are asynchronous and clock ticks come on clk
`timescale 1ns/1ps
module pei_handler (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       link_clk,
  input  wire logic       cmd_valid,
  input  wire logic       cmd_write,
  input  wire logic [7:0] cmd_addr,
  input  wire logic [7:0] cmd_wdata,
  output logic            cmd_ready,
  output logic            rsp_valid,
  output logic [7:0]      rsp_rdata,
  input  wire logic       short_circuit_source,
  input  wire logic       battery_charged_source,
  input  wire logic       hot_die_source,
  input  wire logic       bus_power_present_source,
  input  wire logic       power_button_n,
  input  wire logic       alarm_match,
  input  wire logic       second_tick,
  input  wire logic       minute_tick,
  input  wire logic       hour_tick,
  input  wire logic       day_tick,
  output logic            irq_line_low
);
  import pei_pkg::*;

  logic       req_toggle;
  logic       req_write;
  logic [7:0] req_addr;
  logic [7:0] req_wdata;
  logic       ack_toggle;
  logic [7:0] ack_rdata;
  logic       req_s1;
  logic       req_s2;
  logic       req_seen;
  logic       access;
  logic       wr;
  logic       rd;
  logic [7:0] read_value;

  logic [7:0] event_status;
  logic [7:0] event_mask;
  logic [7:0] edge_enable_first;
  logic [7:0] edge_enable_second;
  logic [7:0] handler_control;
  logic [7:0] clock_irq_ctrl;
  logic       alarm_flag;
  logic       periodic_pulse;
  logic       clock_event_source;
  logic       clock_prev;

  logic [4:0] pin_s1;
  logic [4:0] pin_s2;
  logic [4:0] level_prev;
  logic [4:0] level;
  logic [4:0] rise;
  logic [4:0] fall;
  logic       clock_rise;
  logic       clock_fall;
  logic [7:0] event_set;
  logic [7:0] recorded;
  logic [7:0] clear_bits;
  logic [7:0] next_status;
  logic       clear_on_read;
  logic       pend_block;
  logic       tick_selected;

  function automatic logic edge_hit(input logic up, input logic dn,
                                    input logic up_en, input logic dn_en);
    return (up && up_en) || (dn && dn_en);
  endfunction

  pei_link_port u_link (
    .link_clk   (link_clk),
    .reset      (reset),
    .cmd_valid  (cmd_valid),
    .cmd_write  (cmd_write),
    .cmd_addr   (cmd_addr),
    .cmd_wdata  (cmd_wdata),
    .cmd_ready  (cmd_ready),
    .rsp_valid  (rsp_valid),
    .rsp_rdata  (rsp_rdata),
    .req_toggle (req_toggle),
    .req_write  (req_write),
    .req_addr   (req_addr),
    .req_wdata  (req_wdata),
    .ack_toggle (ack_toggle),
    .ack_rdata  (ack_rdata)
  );

  // request toggle synchroniser; address and data are held by the link side
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      req_s1   <= 1'b0;
      req_s2   <= 1'b0;
      req_seen <= 1'b0;
    end else begin
      req_s1   <= req_toggle;
      req_s2   <= req_s1;
      req_seen <= req_s2;
    end
  end

  assign access = req_s2 ^ req_seen;
  assign wr     = access && req_write;
  assign rd     = access && !req_write;

  // read mux
  always_comb begin
    unique case (req_addr)
      ADDR_EVENT_STATUS:   read_value = event_status;
      ADDR_EVENT_MASK:     read_value = event_mask;
      ADDR_EDGE_FIRST:     read_value = edge_enable_first;
      ADDR_EDGE_SECOND:    read_value = edge_enable_second;
      ADDR_HANDLER_CTRL:   read_value = handler_control;
      ADDR_CLOCK_IRQ_CTRL: read_value = clock_irq_ctrl;
      ADDR_CLOCK_STATUS:   read_value = {1'b0, alarm_flag, 6'h00};
      default:             read_value = READ_UNMAPPED;
    endcase
  end

  // answer back to the link side
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ack_toggle <= 1'b0;
      ack_rdata  <= 8'h00;
    end else if (access) begin
      ack_toggle <= ~ack_toggle;
      ack_rdata  <= read_value;
    end
  end

  // configuration registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      event_mask         <= RST_MASK;
      edge_enable_first  <= RST_EDGE;
      edge_enable_second <= RST_EDGE;
      handler_control    <= RST_CTRL;
      clock_irq_ctrl     <= RST_CLK_IRQ;
    end else if (wr) begin
      if (req_addr == ADDR_EVENT_MASK) begin
        event_mask <= req_wdata;
      end
      if (req_addr == ADDR_EDGE_FIRST) begin
        edge_enable_first <= req_wdata;
      end
      if (req_addr == ADDR_EDGE_SECOND) begin
        edge_enable_second <= req_wdata;
      end
      if (req_addr == ADDR_HANDLER_CTRL) begin
        handler_control <= req_wdata & CTRL_WRITABLE;
      end
      if (req_addr == ADDR_CLOCK_IRQ_CTRL) begin
        clock_irq_ctrl <= req_wdata;
      end
    end
  end

  // pin synchroniser
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      // button pin idles high, so no false edge follows reset
      pin_s1     <= 5'h01;
      pin_s2     <= 5'h01;
      level_prev <= 5'h00;
    end else begin
      pin_s1 <= {short_circuit_source, battery_charged_source,
                 hot_die_source, bus_power_present_source,
                 power_button_n};
      pin_s2     <= pin_s1;
      level_prev <= level;
    end
  end

  // button sense inverted so that pressed reads high
  assign level = {pin_s2[4:1], ~pin_s2[0]};
  assign rise  = level & ~level_prev;
  assign fall  = ~level & level_prev;

  // clock event: alarm flag or periodic pulse
  always_comb begin
    unique case (pei_period_t'(clock_irq_ctrl[CI_PERIOD_LSB +: 2]))
      PEI_EVERY_SECOND: tick_selected = second_tick;
      PEI_EVERY_MINUTE: tick_selected = minute_tick;
      PEI_EVERY_HOUR:   tick_selected = hour_tick;
      PEI_EVERY_DAY:    tick_selected = day_tick;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      periodic_pulse <= 1'b0;
    end else begin
      periodic_pulse <= clock_irq_ctrl[CI_PERIODIC_EN_BIT]
                        && tick_selected;
    end
  end

  // alarm flag: set wins over the host acknowledge
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      alarm_flag <= 1'b0;
    end else if (alarm_match && clock_irq_ctrl[CI_ALARM_EN_BIT]) begin
      alarm_flag <= 1'b1;
    end else if (wr && req_addr == ADDR_CLOCK_STATUS
                 && req_wdata[CS_ALARM_BIT]) begin
      alarm_flag <= 1'b0;
    end
  end

  assign clock_event_source = alarm_flag || periodic_pulse;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      clock_prev <= 1'b0;
    end else begin
      clock_prev <= clock_event_source;
    end
  end

  assign clock_rise = clock_event_source && !clock_prev;
  assign clock_fall = !clock_event_source && clock_prev;

  // enabled edges per source
  always_comb begin
    event_set = 8'h00;
    event_set[BIT_SHORT] = edge_hit(rise[4], fall[4],
      edge_enable_second[ES_SHORT_UP], edge_enable_second[ES_SHORT_DN]);
    event_set[BIT_BATT] = edge_hit(rise[3], fall[3],
      edge_enable_second[ES_BATT_UP], edge_enable_second[ES_BATT_DN]);
    event_set[BIT_HOT] = edge_hit(rise[2], fall[2],
      edge_enable_second[ES_HOT_UP], edge_enable_second[ES_HOT_DN]);
    event_set[BIT_CLOCK] = edge_hit(clock_rise, clock_fall,
      edge_enable_first[EF_CLOCK_UP], edge_enable_first[EF_CLOCK_DN]);
    event_set[BIT_BUSPWR] = edge_hit(rise[1], fall[1],
      edge_enable_first[EF_BUSPWR_UP], edge_enable_first[EF_BUSPWR_DN]);
    event_set[BIT_BUTTON] = edge_hit(rise[0], fall[0],
      edge_enable_first[EF_BUTTON_UP], edge_enable_first[EF_BUTTON_DN]);
  end

  // control bit at 0 means clear-on-read is in effect
  assign clear_on_read = !handler_control[CTRL_CLR_READ_BIT];
  assign pend_block = handler_control[CTRL_PEND_BIT] && !irq_line_low;
  assign recorded   = pend_block ? 8'h00 : (event_set & STATUS_VALID);

  always_comb begin
    clear_bits = 8'h00;
    if (wr && req_addr == ADDR_EVENT_STATUS) begin
      clear_bits = req_wdata;
    end
    if (rd && req_addr == ADDR_EVENT_STATUS && clear_on_read) begin
      clear_bits = 8'hff;
    end
    if (rd && req_addr == ADDR_CLEAR_ALL && !clear_on_read) begin
      clear_bits = 8'hff;
    end
  end

  // new events win over a clear in the same cycle
  assign next_status = ((event_status & ~clear_bits) | recorded)
                       & STATUS_VALID;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      event_status <= RST_STATUS;
    end else begin
      event_status <= next_status;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      irq_line_low <= 1'b1;
    end else begin
      irq_line_low <= ~|(event_status & ~event_mask
                         & STATUS_VALID);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_mask_blocks_irq: assert property (
    ((event_status & ~event_mask & STATUS_VALID) == 8'h00) |=> irq_line_low
  ) else $error("masked or empty status drives the line");
  a_unmasked_irq: assert property (
    (|(event_status & ~event_mask)) |=> !irq_line_low
  ) else $error("unmasked status left the line released");
  a_reserved_zero: assert property (
    (event_status & ~STATUS_VALID) == 8'h00
  ) else $error("reserved status bit set");
  a_button_inverted: assert property (
    $past(pin_s2[0]) && !pin_s2[0] && edge_enable_first[EF_BUTTON_UP]
    && !pend_block |=> event_status[BIT_BUTTON]
  ) else $error("button press not recorded");
  a_read_clears: assert property (
    rd && req_addr == ADDR_EVENT_STATUS && clear_on_read && recorded == 8'h00
    |=> event_status == 8'h00 ##1 irq_line_low
  ) else $error("clear-on-read did not clear");
  a_plain_read_keeps: assert property (
    rd && req_addr == ADDR_EVENT_STATUS && !clear_on_read
    |=> (event_status & $past(event_status)) == $past(event_status)
  ) else $error("plain read cleared status");
  a_clear_addr: assert property (
    rd && req_addr == ADDR_CLEAR_ALL && !clear_on_read && recorded == 8'h00
    |=> event_status == 8'h00
  ) else $error("clear address did not clear");
  a_periodic_off: assert property (
    !clock_irq_ctrl[CI_PERIODIC_EN_BIT] |=> !periodic_pulse
  ) else $error("periodic event while disabled");
  a_alarm_set: assert property (
    alarm_match && clock_irq_ctrl[CI_ALARM_EN_BIT] |=> alarm_flag
  ) else $error("alarm match not flagged");
  a_alarm_hold: assert property (
    alarm_flag && !(wr && req_addr == ADDR_CLOCK_STATUS) |=> alarm_flag
  ) else $error("alarm flag dropped without acknowledge");
  a_pend_drop: assert property (
    pend_block && !(wr || rd) |=> event_status == $past(event_status)
  ) else $error("event recorded during pending disable");
  a_sync_path: assert property (
    rise[4] && edge_enable_second[ES_SHORT_UP] && !pend_block
    |-> $past(pin_s1[4], 2) == 1'b0 ##1 event_status[BIT_SHORT]
  ) else $error("short circuit edge lost");

  c_read_clear: cover property (
    rd && req_addr == ADDR_EVENT_STATUS && clear_on_read && |event_status);
  c_alarm_irq: cover property (alarm_flag ##[1:4] !irq_line_low);
  c_pend_drop: cover property (pend_block && |event_set);
  c_clear_addr: cover property (rd && req_addr == ADDR_CLEAR_ALL);
endmodule // pei_handler

//--- pei_host_model.sv
// host-side model that issues register accesses on the link port
// assumes one outstanding access and a free-running link clock
`timescale 1ns/1ps
module pei_host_model (
  input  wire logic       link_clk,
  input  wire logic       cmd_ready,
  input  wire logic       rsp_valid,
  input  wire logic [7:0] rsp_rdata,
  output logic            cmd_valid,
  output logic            cmd_write,
  output logic [7:0]      cmd_addr,
  output logic [7:0]      cmd_wdata
);
  initial begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_addr  = 8'h00;
    cmd_wdata = 8'h00;
  end

  // hold the request until taken, then wait for the answer
  task automatic access(input logic w, input logic [7:0] a,
                        input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    q = 8'hxx;
    @(posedge link_clk);
    #1;
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_addr  = a;
    cmd_wdata = d;
    @(posedge link_clk);
    while (cmd_ready !== 1'b1 && n < 40) begin
      n++;
      @(posedge link_clk);
    end
    #1;
    cmd_valid = 1'b0;
    // released lines show the inverse of the last value
    cmd_write = ~w;
    cmd_addr  = ~a;
    cmd_wdata = ~d;
    @(posedge link_clk);
    while (rsp_valid !== 1'b1 && n < 60) begin
      n++;
      @(posedge link_clk);
    end
    if (rsp_valid === 1'b1) q = rsp_rdata;
  endtask
endmodule // pei_host_model

//--- pei_link_port.sv
// link-side register port, runs on the link clock
// assumes the core answers each request toggle with one ack toggle
`timescale 1ns/1ps
module pei_link_port (
  input  wire logic       link_clk,
  input  wire logic       reset,
  input  wire logic       cmd_valid,
  input  wire logic       cmd_write,
  input  wire logic [7:0] cmd_addr,
  input  wire logic [7:0] cmd_wdata,
  output logic            cmd_ready,
  output logic            rsp_valid,
  output logic [7:0]      rsp_rdata,
  output logic            req_toggle,
  output logic            req_write,
  output logic [7:0]      req_addr,
  output logic [7:0]      req_wdata,
  input  wire logic       ack_toggle,
  input  wire logic [7:0] ack_rdata
);
  logic busy;
  logic ack_s1;
  logic ack_s2;
  logic ack_seen;
  logic done;

  assign cmd_ready = ~busy;
  assign done      = ack_s2 ^ ack_seen;

  // ack toggle synchroniser
  always_ff @(posedge link_clk or posedge reset) begin
    if (reset) begin
      ack_s1   <= 1'b0;
      ack_s2   <= 1'b0;
      ack_seen <= 1'b0;
    end else begin
      ack_s1   <= ack_toggle;
      ack_s2   <= ack_s1;
      ack_seen <= ack_s2;
    end
  end

  // request capture, held stable until the ack returns
  always_ff @(posedge link_clk or posedge reset) begin
    if (reset) begin
      busy       <= 1'b0;
      req_toggle <= 1'b0;
      req_write  <= 1'b0;
      req_addr   <= 8'h00;
      req_wdata  <= 8'h00;
    end else if (cmd_valid && !busy) begin
      busy       <= 1'b1;
      req_toggle <= ~req_toggle;
      req_write  <= cmd_write;
      req_addr   <= cmd_addr;
      req_wdata  <= cmd_wdata;
    end else if (done) begin
      busy <= 1'b0;
    end
  end

  // answer
  always_ff @(posedge link_clk or posedge reset) begin
    if (reset) begin
      rsp_valid <= 1'b0;
      rsp_rdata <= 8'h00;
    end else begin
      rsp_valid <= done;
      if (done) begin
        rsp_rdata <= ack_rdata;
      end
    end
  end
endmodule // pei_link_port

//--- pei_pkg.sv
// constants for the power event interrupt handler
// assumes an 8-bit register map reached through the link-side port
package pei_pkg;

  // register addresses
  localparam logic [7:0] ADDR_CLOCK_STATUS   = 8'h2a;
  localparam logic [7:0] ADDR_CLOCK_IRQ_CTRL = 8'h2b;
  localparam logic [7:0] ADDR_EVENT_STATUS   = 8'h2e;
  localparam logic [7:0] ADDR_EVENT_MASK     = 8'h2f;
  localparam logic [7:0] ADDR_CLEAR_ALL      = 8'h31;
  localparam logic [7:0] ADDR_EDGE_FIRST     = 8'h33;
  localparam logic [7:0] ADDR_EDGE_SECOND    = 8'h34;
  localparam logic [7:0] ADDR_HANDLER_CTRL   = 8'h35;

  // status and mask bit positions
  localparam int BIT_SHORT  = 7;
  localparam int BIT_BATT   = 6;
  localparam int BIT_HOT    = 4;
  localparam int BIT_CLOCK  = 3;
  localparam int BIT_BUSPWR = 2;
  localparam int BIT_BUTTON = 0;
  localparam logic [7:0] STATUS_VALID = 8'hdd;

  // first edge-enable register fields
  localparam int EF_CLOCK_UP  = 7;
  localparam int EF_CLOCK_DN  = 6;
  localparam int EF_BUSPWR_UP = 5;
  localparam int EF_BUSPWR_DN = 4;
  localparam int EF_BUTTON_UP = 1;
  localparam int EF_BUTTON_DN = 0;

  // second edge-enable register fields
  localparam int ES_SHORT_UP = 7;
  localparam int ES_SHORT_DN = 6;
  localparam int ES_BATT_UP  = 5;
  localparam int ES_BATT_DN  = 4;
  localparam int ES_HOT_UP   = 1;
  localparam int ES_HOT_DN   = 0;

  // handler control fields
  localparam int CTRL_CLR_READ_BIT = 2;
  localparam int CTRL_PEND_BIT     = 1;
  localparam logic [7:0] CTRL_WRITABLE = 8'h07;

  // clock interrupt control and clock status fields
  localparam int CI_ALARM_EN_BIT    = 3;
  localparam int CI_PERIODIC_EN_BIT = 2;
  localparam int CI_PERIOD_LSB      = 0;
  localparam int CS_ALARM_BIT       = 6;

  // reset values
  localparam logic [7:0] RST_STATUS  = 8'h00;
  localparam logic [7:0] RST_MASK    = 8'h00;
  localparam logic [7:0] RST_EDGE    = 8'hf3;
  localparam logic [7:0] RST_CTRL    = 8'h01;
  localparam logic [7:0] RST_CLK_IRQ = 8'h00;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  typedef enum logic [1:0] {
    PEI_EVERY_SECOND = 2'h0,
    PEI_EVERY_MINUTE = 2'h1,
    PEI_EVERY_HOUR   = 2'h2,
    PEI_EVERY_DAY    = 2'h3
  } pei_period_t;

endpackage

//--- testbench.sv
// self-checking bench for the power event interrupt handler
// assumes the host model sits on the link-side register port
`timescale 1ns/1ps
module testbench;
  import pei_pkg::*;
  logic       clk, lclk, reset, pb_n;
  logic       cv, cw, crdy, rv;
  logic [7:0] ca, cd, rd_q;
  logic [3:0] src;
  logic [4:0] tk;
  logic       irq;
  int         n_mismatch, check_count;
  int         pos [4] = '{BIT_SHORT, BIT_BATT, BIT_HOT, BIT_BUSPWR};

  pei_handler i_pei_handler (
    .clk(clk), .reset(reset), .link_clk(lclk),
    .cmd_valid(cv), .cmd_write(cw), .cmd_addr(ca), .cmd_wdata(cd),
    .cmd_ready(crdy), .rsp_valid(rv), .rsp_rdata(rd_q),
    .short_circuit_source(src[0]), .battery_charged_source(src[1]),
    .hot_die_source(src[2]), .bus_power_present_source(src[3]),
    .power_button_n(pb_n), .alarm_match(tk[4]),
    .second_tick(tk[0]), .minute_tick(tk[1]), .hour_tick(tk[2]),
    .day_tick(tk[3]), .irq_line_low(irq));

  pei_host_model i_pei_host_model (
    .link_clk(lclk), .cmd_ready(crdy), .rsp_valid(rv),
    .rsp_rdata(rd_q), .cmd_valid(cv), .cmd_write(cw),
    .cmd_addr(ca), .cmd_wdata(cd));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    lclk = 1'b0;
    #3.3;
    forever #7.5 lclk = ~lclk;
  end

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic chk1(input logic g, input logic e);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    i_pei_host_model.access(1'b0, a, 8'h00, q);
    chk8(q, e);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    i_pei_host_model.access(1'b1, a, d, q);
    if (^q === 1'bx) begin
      n_mismatch++;
      $display("mismatch t=%0t no write answer got=%h exp=%h", $time, q, d);
    end
  endtask

  task automatic settle;
    repeat (10) @(posedge clk);
    #1;
  endtask

  task automatic pin(input int i, input logic v);
    @(posedge clk);
    #1 src[i] = v;
    settle();
  endtask

  task automatic btn(input logic v);
    @(posedge clk);
    #1 pb_n = v;
    settle();
  endtask

  task automatic tick(input int i);
    @(posedge clk);
    #1 tk[i] = 1'b1;
    @(posedge clk);
    #1 tk[i] = 1'b0;
    settle();
  endtask

  task automatic t_reset_values;
    rd(ADDR_EVENT_STATUS, RST_STATUS);
    rd(ADDR_EVENT_MASK, RST_MASK);
    rd(ADDR_EDGE_FIRST, RST_EDGE);
    rd(ADDR_EDGE_SECOND, RST_EDGE);
    rd(ADDR_HANDLER_CTRL, RST_CTRL);
    rd(ADDR_CLOCK_IRQ_CTRL, RST_CLK_IRQ);
    rd(8'h40, READ_UNMAPPED);
    chk1(irq, 1'b1);
  endtask

  task automatic t_sources;
    for (int i = 0; i < 4; i++) begin
      pin(i, 1'b1);
      chk1(irq, 1'b0);
      rd(ADDR_EVENT_STATUS, 8'h01 << pos[i]);
      rd(ADDR_EVENT_STATUS, 8'h00);
      chk1(irq, 1'b1);
      pin(i, 1'b0);
      rd(ADDR_EVENT_STATUS, 8'h01 << pos[i]);
    end
    wr(ADDR_EDGE_SECOND, 8'h00);
    pin(0, 1'b1);
    rd(ADDR_EVENT_STATUS, 8'h00);
    pin(0, 1'b0);
    wr(ADDR_EDGE_SECOND, RST_EDGE);
  endtask

  task automatic t_button;
    wr(ADDR_EDGE_FIRST, 8'h02);
    btn(1'b0);
    rd(ADDR_EVENT_STATUS, 8'h01);
    btn(1'b1);
    rd(ADDR_EVENT_STATUS, 8'h00);
    wr(ADDR_EDGE_FIRST, 8'h01);
    btn(1'b0);
    rd(ADDR_EVENT_STATUS, 8'h00);
    btn(1'b1);
    rd(ADDR_EVENT_STATUS, 8'h01);
    wr(ADDR_EDGE_FIRST, RST_EDGE);
  endtask

  task automatic t_mask;
    wr(ADDR_EVENT_MASK, 8'h80);
    rd(ADDR_EVENT_MASK, 8'h80);
    pin(0, 1'b1);
    chk1(irq, 1'b1);
    wr(ADDR_EVENT_MASK, 8'h00);
    settle();
    chk1(irq, 1'b0);
    rd(ADDR_EVENT_STATUS, 8'h80);
    pin(0, 1'b0);
    rd(ADDR_EVENT_STATUS, 8'h80);
  endtask

  task automatic t_no_cor;
    logic [7:0] q;
    wr(ADDR_HANDLER_CTRL, 8'h05);
    pin(1, 1'b1);
    rd(ADDR_EVENT_STATUS, 8'h40);
    rd(ADDR_EVENT_STATUS, 8'h40);
    chk1(irq, 1'b0);
    i_pei_host_model.access(1'b0, ADDR_CLEAR_ALL, 8'h00, q);
    chk1(irq, 1'b1);
    rd(ADDR_EVENT_STATUS, 8'h00);
    pin(1, 1'b0);
    rd(ADDR_EVENT_STATUS, 8'h40);
    wr(ADDR_EVENT_STATUS, 8'h40);
    rd(ADDR_EVENT_STATUS, 8'h00);
    chk1(irq, 1'b1);
    i_pei_host_model.access(1'b0, ADDR_CLEAR_ALL, 8'h00, q);
    wr(ADDR_HANDLER_CTRL, RST_CTRL);
  endtask

  task automatic t_pending;
    wr(ADDR_HANDLER_CTRL, 8'h03);
    pin(0, 1'b1);
    pin(1, 1'b1);
    rd(ADDR_EVENT_STATUS, 8'h80);
    pin(0, 1'b0);
    pin(1, 1'b0);
    rd(ADDR_EVENT_STATUS, 8'h80);
    wr(ADDR_HANDLER_CTRL, RST_CTRL);
  endtask

  task automatic t_periodic;
    for (int p = 0; p < 4; p++) begin
      wr(ADDR_CLOCK_IRQ_CTRL, 8'h04 | 8'(p));
      rd(ADDR_CLOCK_IRQ_CTRL, 8'h04 | 8'(p));
      tick((p + 1) % 4);
      rd(ADDR_EVENT_STATUS, 8'h00);
      tick(p);
      rd(ADDR_EVENT_STATUS, 8'h08);
    end
    wr(ADDR_CLOCK_IRQ_CTRL, 8'h00);
    tick(0);
    rd(ADDR_EVENT_STATUS, 8'h00);
  endtask

  task automatic t_alarm;
    tick(4);
    rd(ADDR_CLOCK_STATUS, 8'h00);
    wr(ADDR_CLOCK_IRQ_CTRL, 8'h08);
    tick(4);
    rd(ADDR_EVENT_STATUS, 8'h08);
    rd(ADDR_CLOCK_STATUS, 8'h40);
    settle();
    rd(ADDR_EVENT_STATUS, 8'h00);
    wr(ADDR_CLOCK_STATUS, 8'h40);
    settle();
    rd(ADDR_CLOCK_STATUS, 8'h00);
    rd(ADDR_EVENT_STATUS, 8'h08);
    wr(ADDR_CLOCK_IRQ_CTRL, 8'h00);
  endtask

  initial begin
    #100000;
    n_mismatch++;
    give_verdict();
  end

  initial begin
    n_mismatch = 0;
    check_count = 0;
    reset = 1'b1;
    pb_n = 1'b1;
    src = 4'h0;
    tk = 5'h00;
    repeat (12) @(posedge clk);
    #1 reset = 1'b0;
    t_reset_values();
    t_sources();
    t_button();
    t_mask();
    t_no_cor();
    t_pending();
    t_periodic();
    t_alarm();
    give_verdict();
  end
endmodule // testbench
